// file: test/input_loop_ref_feedback_select_test.sv
// Testbench for the input loop selector
`timescale 1ns/1ps
`default_nettype none
module input_loop_ref_feedback_select_test;
    localparam logic [9:0] ZD = loop_select_pkg::ZD_MODE_OFFSET;
    localparam logic [9:0] MS = loop_select_pkg::MISC_CTRL_OFFSET;
    logic ref_clk_i = 0, reset_n_i = 0, clk_en_i = 1, reg_write_i = 0, reg_read_i = 0;
    logic primary_diff_en_i = 0, secondary_diff_en_i = 0, ref_choice_pin_i = 0;
    logic primary_fail_i = 0, secondary_fail_i = 0;
    logic [9:0] reg_addr_i = 10'h000;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    loop_select_pkg::feedback_src_t fb_src_o;
    logic zd_rx_enable_o, zd_rx_diff_o, zd_rx_pin_sel_o, primary_rx_pin_sel_o;
    logic secondary_rx_pin_sel_o, secondary_div_own_o, tune_midsupply_o, use_secondary_o;
    int mismatches = 0, checks = 0;
    input_loop_ref_feedback_select i_dut (.*);
    // Clock and watchdog
    initial forever #4 ref_clk_i = ~ref_clk_i;
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        mismatches++;
        results();
    end
    // Bus cycles, compare and verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_read_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    task automatic st;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic results;
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(ZD, 8'h00);
        rd(MS, 8'h00);
        chk(zd_rx_enable_o, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wr(ZD, 8'(i << 4));
            st();
            chk(fb_src_o, i[0] ? 8'h02 : 8'(i[1]));
            chk(zd_rx_enable_o, 8'(i == 0));
        end
        for (int i = 0; i < 64; i++)
        begin
            primary_diff_en_i <= i[4];
            secondary_diff_en_i <= i[5];
            wr(ZD, 8'(i[3:0]));
            st();
            chk(zd_rx_diff_o, 8'(i[2]));
            chk(zd_rx_pin_sel_o, 8'(i[3] & ~i[2]));
            chk(primary_rx_pin_sel_o, 8'(i[0] & ~i[4]));
            chk(secondary_rx_pin_sel_o, 8'(i[1] & ~i[5]));
        end
        wr(ZD, 8'hff);
        rd(ZD, 8'h3f);
        wr(MS, 8'hff);
        rd(MS, 8'hdc);
        wr(10'h01d, 8'h5a);
        rd(10'h01d, 8'h00);
        wr(MS, 8'h08);
        st();
        chk(use_secondary_o, 8'h00);
        wr(MS, 8'h0c);
        st();
        chk(use_secondary_o, 8'h01);
        for (int p = 0; p < 2; p++)
        begin
            ref_choice_pin_i <= p[0];
            wr(MS, p[0] ? 8'h10 : 8'h1c);
            st();
            chk(use_secondary_o, 8'(p));
        end
        wr(MS, 8'h08);
        primary_fail_i <= 1'b1;
        wr(MS, 8'h00);
        st();
        chk(use_secondary_o, 8'h01);
        primary_fail_i <= 1'b0;
        st();
        chk(use_secondary_o, 8'h01);
        primary_fail_i <= 1'b1;
        wr(MS, 8'h04);
        st();
        chk(use_secondary_o, 8'h01);
        primary_fail_i <= 1'b0;
        st();
        chk(use_secondary_o, 8'h00);
        secondary_fail_i <= 1'b1;
        primary_fail_i <= 1'b1;
        st();
        chk(use_secondary_o, 8'h00);
        secondary_fail_i <= 1'b0;
        primary_fail_i <= 1'b1;
        wr(MS, 8'hc8);
        st();
        chk(tune_midsupply_o, 8'h01);
        chk(secondary_div_own_o, 8'h01);
        rd(loop_select_pkg::STATUS_OFFSET, 8'h06);
        wr(MS, 8'h08);
        st();
        chk(tune_midsupply_o, 8'h00);
        chk(secondary_div_own_o, 8'h00);
        clk_en_i <= 1'b0;
        wr(ZD, 8'h00);
        clk_en_i <= 1'b1;
        rd(ZD, 8'h3f);
        chk(fb_src_o, 8'h02);
        chk(zd_rx_enable_o, 8'h00);
        results();
    end
endmodule
`default_nettype wire

// file: test/loop_select_sva.sv
// Port checker for the input loop selector
`timescale 1ns/1ps
`default_nettype none
module loop_select_sva (
    input wire logic                           ref_clk_i,
    input wire logic                           reset_n_i,
    input wire logic                           clk_en_i,
    input wire logic [9:0]                     reg_addr_i,
    input wire logic [7:0]                     reg_wdata_i,
    input wire logic                           reg_write_i,
    input wire logic                           reg_read_i,
    input wire logic [7:0]                     reg_rdata_o,
    input wire logic                           primary_diff_en_i,
    input wire logic                           ref_choice_pin_i,
    input wire loop_select_pkg::feedback_src_t fb_src_o,
    input wire logic                           zd_rx_enable_o,
    input wire logic                           zd_rx_diff_o,
    input wire logic                           zd_rx_pin_sel_o,
    input wire logic                           primary_rx_pin_sel_o,
    input wire logic                           secondary_div_own_o,
    input wire logic                           use_secondary_o
);
    logic [7:0] zd_q, zd_d, ms_q, ms_d;
    // Shadow copies of both control registers
    always_comb
    begin
        zd_d = zd_q;
        ms_d = ms_q;
        if (reg_write_i && reg_addr_i == loop_select_pkg::ZD_MODE_OFFSET)
            zd_d = reg_wdata_i & loop_select_pkg::ZD_MODE_WMASK;
        if (reg_write_i && reg_addr_i == loop_select_pkg::MISC_CTRL_OFFSET)
            ms_d = reg_wdata_i & loop_select_pkg::MISC_CTRL_WMASK;
    end
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            zd_q <= 8'h00;
            ms_q <= 8'h00;
        end
        else if (clk_en_i)
        begin
            zd_q <= zd_d;
            ms_q <= ms_d;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Relations between register contents and outputs
    a_rx_enable: assert property (zd_rx_enable_o == (!zd_q[4] && !zd_q[5]))
        else $error("zero delay receiver enable wrong");
    a_fb_path: assert property (fb_src_o == ($past(zd_q[4]) ? 2'b10 : {1'b0, $past(zd_q[5])}))
        else $error("feedback source wrong");
    a_zd_diff: assert property (zd_rx_diff_o == zd_q[2])
        else $error("zero delay differential wrong");
    a_zd_pin: assert property (zd_rx_pin_sel_o == (zd_q[3] && !zd_q[2]))
        else $error("zero delay pin select wrong");
    a_pri_pin: assert property (primary_rx_pin_sel_o == (zd_q[0] && !primary_diff_en_i))
        else $error("primary pin select wrong");
    a_div_own: assert property (secondary_div_own_o == $past(ms_q[7]))
        else $error("secondary divider control wrong");
    a_forced_ref: assert property ((ms_q[4:3] == 2'b01 && $stable(ms_q[2]))[*3]
        |=> use_secondary_o == $past(ms_q[2])) else $error("forced reference wrong");
    a_pin_ref: assert property ((ms_q[4] && $stable(ref_choice_pin_i))[*3]
        |=> use_secondary_o == $past(ref_choice_pin_i)) else $error("pin reference wrong");
    a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero when idle");
    // Clock enable low holds use_secondary_o and fb_src_o
    a_freeze_hold: assert property (!clk_en_i |=> $stable(use_secondary_o) && $stable(fb_src_o))
        else $error("loop controls changed while frozen");
endmodule
bind input_loop_ref_feedback_select loop_select_sva i_sva (.*);
`default_nettype wire

// file: verilog/feedback_route.sv
// Feedback path and receiver mode decode
`timescale 1ns/1ps
`default_nettype none
module feedback_route (
    input  wire logic                  fb_osc_i,
    input  wire logic                  zd_internal_i,
    input  wire logic                  zd_diff_i,
    input  wire logic                  zd_se_sel_i,
    input  wire logic                  pri_diff_i,
    input  wire logic                  pri_se_sel_i,
    input  wire logic                  sec_diff_i,
    input  wire logic                  sec_se_sel_i,
    output loop_select_pkg::feedback_src_t fb_src_o,
    output loop_select_pkg::rx_cfg_t   rx_cfg_o
);
    // Feedback source: oscillator, or zero delay path chosen by mode bit
    always_comb
    begin
        if (fb_osc_i)
            fb_src_o = loop_select_pkg::FB_OSC_INPUT;
        else if (zd_internal_i)
            fb_src_o = loop_select_pkg::FB_ZD_INTERNAL;
        else
            fb_src_o = loop_select_pkg::FB_ZD_EXTERNAL;
    end

    // Receiver modes; pin selects only count in single-ended mode
    always_comb
    begin
        rx_cfg_o.zd_rx_enable   = (fb_src_o == loop_select_pkg::FB_ZD_EXTERNAL);
        rx_cfg_o.zd_rx_diff     = zd_diff_i;
        rx_cfg_o.zd_rx_pin_sel  = zd_diff_i ? 1'b0 : zd_se_sel_i;
        rx_cfg_o.pri_rx_pin_sel = pri_diff_i ? 1'b0 : pri_se_sel_i;
        rx_cfg_o.sec_rx_pin_sel = sec_diff_i ? 1'b0 : sec_se_sel_i;
    end
endmodule
`default_nettype wire

// file: verilog/input_loop_ref_feedback_select.sv
// Input loop feedback and reference selection with its two control registers
`timescale 1ns/1ps
`default_nettype none
module input_loop_ref_feedback_select (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        clk_en_i,
    input  wire logic [9:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        primary_diff_en_i,
    input  wire logic        secondary_diff_en_i,
    input  wire logic        ref_choice_pin_i,
    input  wire logic        primary_fail_i,
    input  wire logic        secondary_fail_i,
    output loop_select_pkg::feedback_src_t fb_src_o,
    output logic             zd_rx_enable_o,
    output logic             zd_rx_diff_o,
    output logic             zd_rx_pin_sel_o,
    output logic             primary_rx_pin_sel_o,
    output logic             secondary_rx_pin_sel_o,
    output logic             secondary_div_own_o,
    output logic             tune_midsupply_o,
    output logic             use_secondary_o
);
    logic [7:0]                     zd_mode_q;
    logic [7:0]                     zd_mode_d;
    logic [7:0]                     misc_q;
    logic [7:0]                     misc_d;
    logic [7:0]                     rdata_q;
    logic [7:0]                     rdata_d;
    loop_select_pkg::rx_cfg_t       rx_cfg;
    loop_select_pkg::feedback_src_t fb_src;
    loop_select_pkg::loop_ctrl_t    ctrl_d;
    loop_select_pkg::loop_ctrl_t    ctrl_q;
    logic                           use_sec;
    logic                           active_fail;

    // Register writes; reserved bits stay zero
    always_comb
    begin
        zd_mode_d = zd_mode_q;
        misc_d    = misc_q;
        if (reg_write_i && reg_addr_i == loop_select_pkg::ZD_MODE_OFFSET)
            zd_mode_d = reg_wdata_i & loop_select_pkg::ZD_MODE_WMASK;
        if (reg_write_i && reg_addr_i == loop_select_pkg::MISC_CTRL_OFFSET)
            misc_d = reg_wdata_i & loop_select_pkg::MISC_CTRL_WMASK;
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_read_i)
        begin
            unique case (reg_addr_i)
                loop_select_pkg::ZD_MODE_OFFSET:   rdata_d = zd_mode_q;
                loop_select_pkg::MISC_CTRL_OFFSET: rdata_d = misc_q;
                loop_select_pkg::STATUS_OFFSET:
                    rdata_d = {4'h0, use_sec, ctrl_q.tune_midsupply, fb_src};
                default:                           rdata_d = 8'h00;
            endcase
        end
    end

    // Register state
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            zd_mode_q <= loop_select_pkg::ZD_MODE_RESET;
            misc_q    <= loop_select_pkg::MISC_CTRL_RESET;
            rdata_q   <= 8'h00;
        end
        else if (clk_en_i)
        begin
            zd_mode_q <= zd_mode_d;
            misc_q    <= misc_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // Feedback path and receiver decode
    feedback_route u_route (
        .fb_osc_i      (zd_mode_q[loop_select_pkg::FB_OSC_BIT]),
        .zd_internal_i (zd_mode_q[loop_select_pkg::ZD_INTERNAL_BIT]),
        .zd_diff_i     (zd_mode_q[loop_select_pkg::ZD_DIFF_BIT]),
        .zd_se_sel_i   (zd_mode_q[loop_select_pkg::ZD_SE_SEL_BIT]),
        .pri_diff_i    (primary_diff_en_i),
        .pri_se_sel_i  (zd_mode_q[loop_select_pkg::PRI_SE_SEL_BIT]),
        .sec_diff_i    (secondary_diff_en_i),
        .sec_se_sel_i  (zd_mode_q[loop_select_pkg::SEC_SE_SEL_BIT]),
        .fb_src_o      (fb_src),
        .rx_cfg_o      (rx_cfg)
    );

    // Reference choice state
    reference_chooser u_chooser (
        .ref_clk_i        (ref_clk_i),
        .reset_n_i        (reset_n_i),
        .clk_en_i         (clk_en_i),
        .mode_i           (loop_select_pkg::ref_mode_t'(misc_q[loop_select_pkg::REF_SEL_LSB +: 3])),
        .ref_choice_pin_i (ref_choice_pin_i),
        .primary_fail_i   (primary_fail_i),
        .secondary_fail_i (secondary_fail_i),
        .use_secondary_o  (use_sec)
    );

    // Failure of the reference in use
    assign active_fail = use_sec ? secondary_fail_i : primary_fail_i;

    // Registered loop controls
    always_comb
    begin
        ctrl_d.fb_src         = fb_src;
        ctrl_d.sec_div_own    = misc_q[loop_select_pkg::SEC_INDEP_DIV_BIT];
        ctrl_d.tune_midsupply = misc_q[loop_select_pkg::MIDSUPPLY_BIT]
                                && active_fail;
        ctrl_d.use_secondary  = use_sec;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ctrl_q <= '0;
        else if (clk_en_i)
            ctrl_q <= ctrl_d;
    end

    assign fb_src_o               = ctrl_q.fb_src;
    assign secondary_div_own_o    = ctrl_q.sec_div_own;
    assign tune_midsupply_o       = ctrl_q.tune_midsupply;
    assign use_secondary_o        = ctrl_q.use_secondary;
    assign zd_rx_enable_o         = rx_cfg.zd_rx_enable;
    assign zd_rx_diff_o           = rx_cfg.zd_rx_diff;
    assign zd_rx_pin_sel_o        = rx_cfg.zd_rx_pin_sel;
    assign primary_rx_pin_sel_o   = rx_cfg.pri_rx_pin_sel;
    assign secondary_rx_pin_sel_o = rx_cfg.sec_rx_pin_sel;
endmodule
`default_nettype wire

// file: verilog/loop_select_pkg.sv
// Package with register map, field positions and types for the input loop selector
package loop_select_pkg;

    // Register offsets
    localparam logic [9:0] ZD_MODE_OFFSET   = 10'h01b;
    localparam logic [9:0] MISC_CTRL_OFFSET = 10'h01c;
    localparam logic [9:0] STATUS_OFFSET    = 10'h01f;

    // Reset values and write masks
    localparam logic [7:0] ZD_MODE_RESET    = 8'h00;
    localparam logic [7:0] MISC_CTRL_RESET  = 8'h00;
    localparam logic [7:0] ZD_MODE_WMASK    = 8'h3f;
    localparam logic [7:0] MISC_CTRL_WMASK  = 8'hdc;

    // Field positions, zero delay register
    localparam int ZD_INTERNAL_BIT   = 5;
    localparam int FB_OSC_BIT        = 4;
    localparam int ZD_SE_SEL_BIT     = 3;
    localparam int ZD_DIFF_BIT       = 2;
    localparam int SEC_SE_SEL_BIT    = 1;
    localparam int PRI_SE_SEL_BIT    = 0;

    // Field positions, misc register
    localparam int SEC_INDEP_DIV_BIT = 7;
    localparam int MIDSUPPLY_BIT     = 6;
    localparam int REF_SEL_LSB       = 2;

    // Feedback source
    typedef enum logic [1:0] {
        FB_ZD_EXTERNAL = 2'b00,
        FB_ZD_INTERNAL = 2'b01,
        FB_OSC_INPUT   = 2'b10
    } feedback_src_t;

    // Reference selection mode codes
    typedef enum logic [2:0] {
        SEL_NONREVERT  = 3'b000,
        SEL_REVERT_PRI = 3'b001,
        SEL_FORCE_PRI  = 3'b010,
        SEL_FORCE_SEC  = 3'b011,
        SEL_PIN_0      = 3'b100,
        SEL_PIN_1      = 3'b101,
        SEL_PIN_2      = 3'b110,
        SEL_PIN_3      = 3'b111
    } ref_mode_t;

    // Receiver configuration bundle
    typedef struct packed {
        logic zd_rx_enable;
        logic zd_rx_diff;
        logic zd_rx_pin_sel;
        logic pri_rx_pin_sel;
        logic sec_rx_pin_sel;
    } rx_cfg_t;

    // Loop control bundle
    typedef struct packed {
        feedback_src_t fb_src;
        logic          sec_div_own;
        logic          tune_midsupply;
        logic          use_secondary;
    } loop_ctrl_t;

endpackage

// file: verilog/reference_chooser.sv
// Reference selection state: register, revertive and pin modes
`timescale 1ns/1ps
`default_nettype none
module reference_chooser (
    input  wire logic                       ref_clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       clk_en_i,
    input  wire loop_select_pkg::ref_mode_t mode_i,
    input  wire logic                       ref_choice_pin_i,
    input  wire logic                       primary_fail_i,
    input  wire logic                       secondary_fail_i,
    output logic                            use_secondary_o
);
    logic use_sec_q;
    logic use_sec_d;

    // Next reference choice
    always_comb
    begin
        use_sec_d = use_sec_q;
        unique case (mode_i)
            loop_select_pkg::SEL_NONREVERT:
            begin
                if (use_sec_q)
                    use_sec_d = 1'b1;
                else if (primary_fail_i && !secondary_fail_i)
                    use_sec_d = 1'b1;
            end
            loop_select_pkg::SEL_REVERT_PRI:
            begin
                use_sec_d = primary_fail_i && !secondary_fail_i;
            end
            loop_select_pkg::SEL_FORCE_PRI: use_sec_d = 1'b0;
            loop_select_pkg::SEL_FORCE_SEC: use_sec_d = 1'b1;
            loop_select_pkg::SEL_PIN_0,
            loop_select_pkg::SEL_PIN_1,
            loop_select_pkg::SEL_PIN_2,
            loop_select_pkg::SEL_PIN_3:
                use_sec_d = ref_choice_pin_i;
        endcase
    end

    // Choice register
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            use_sec_q <= 1'b0;
        else if (clk_en_i)
            use_sec_q <= use_sec_d;
    end

    assign use_secondary_o = use_sec_q;
endmodule
`default_nettype wire
